// File: shared/bspc_pkg.sv
package bspc_pkg;

  // Register bus geometry
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;

  // Register byte offsets
  localparam logic [7:0]  REG_BOOT_STAT  = 8'h00;
  localparam logic [7:0]  REG_CTRL       = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h0c;
  localparam logic [7:0]  REG_WAKE_EN    = 8'h10;
  localparam logic [1:0]  REG_PAD_PAGE   = 2'h1;   // 0x40 + 4*pad
  localparam logic [1:0]  REG_REMAP_PAGE = 2'h2;   // 0x80 + 4*pad

  // Control register fields
  localparam int          CTRL_CLK_EXT_BIT = 0;
  localparam int          CTRL_SECOND_BIT  = 1;
  localparam int          CTRL_CLK_LOCK_BIT = 2;

  // Interrupt status and mask fields
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_BOOT_BIT   = 0;
  localparam int          IRQ_WAKE_BIT   = 1;
  localparam int          IRQ_REFUSE_BIT = 2;

  // Pad option limits and reset values
  localparam logic [3:0]  DRIVE_MAX_MA   = 4'hc;
  localparam logic [3:0]  DRIVE_MIN_MA   = 4'h1;
  localparam logic [3:0]  DRIVE_RST_MA   = 4'h2;
  localparam logic [2:0]  FUNC_DEDICATED = 3'h0;
  localparam logic [2:0]  FUNC_GPIO      = 3'h1;
  localparam logic [5:0]  REMAP_COUNT    = 6'h24;  // 36 selectable signals
  localparam int          NWAKE          = 12;

  // Cycles after reset release before the strap sample is trusted
  localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

  typedef enum logic [2:0] {
    BOOT_NONE      = 3'b000,
    BOOT_JTAG      = 3'b001,
    BOOT_DDR_FLASH = 3'b010,
    BOOT_MRAM      = 3'b011,
    BOOT_SERIAL    = 3'b100
  } bspc_boot_t;

  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b00,
    SLP_LIGHT  = 2'b01,
    SLP_RETAIN = 2'b10,
    SLP_DEEP   = 2'b11
  } bspc_sleep_t;

  typedef enum logic [1:0] {
    BS_SETTLE = 2'b00,
    BS_LATCH  = 2'b01,
    BS_HOLD   = 2'b10
  } bspc_bstate_t;

  typedef struct packed {
    logic       oe;
    logic       out;
    logic [3:0] drive;
    logic       pull_dn;
    logic       pull_up;
    logic [2:0] func;
  } bspc_pad_cfg_t;

  typedef struct packed {
    logic       en;
    logic [5:0] sel;
  } bspc_remap_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bspc_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic       from_fuse;
    logic       serial_stage;
    bspc_boot_t src;
  } bspc_boot_info_t;

  localparam bspc_pad_cfg_t PAD_CFG_RST = '{oe: 1'b0, out: 1'b0, drive: DRIVE_RST_MA,
                                            pull_dn: 1'b0, pull_up: 1'b0, func: FUNC_GPIO};
  localparam bspc_remap_t   REMAP_RST   = '{en: 1'b0, sel: 6'h00};

endpackage : bspc_pkg

// File: hw/bspc_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pins entering the reference clock domain
module bspc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage is read by the second stage only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : bspc_sync2

// File: hw/bspc_top.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Sample both straps at reset release
// - Straps 00 defer to fuse boot source
// - Straps 01 debug, 10 DDR flash, 11 MRAM
// - Strap-disable fuse forces fuse boot source
// - Serial flash only via fuse or MRAM stage
// - Pads reset to GPIO input, no pulls
// - Reset and debug pads keep dedicated function
// - Remap mux offers 36 signals on remappable pads
// - Twelve enabled wake pads exit deep sleep
// - Always-on pads keep output during sleep
// - Switched pads off in retention and deep sleep, light keeps config
// - Drive strength selectable up to 12mA
// - Weak pulls independent, off until enabled
// - Fast clock source from fuse or bootloader
module bspc_top
  import bspc_pkg::*;
#(
  parameter int          NPAD       = 16,
  parameter logic [15:0] AON_MASK   = 16'h0fff,
  parameter logic [15:0] DED_MASK   = 16'hc000,
  parameter logic [15:0] REMAP_MASK = 16'h00ff
) (
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire bspc_pkg::bspc_bus_req_t bus_req,
  output logic [bspc_pkg::DATA_W-1:0]  bus_rdata,
  input  wire logic                    strap_pad_high,
  input  wire logic                    strap_pad_low,
  input  wire logic                    fuse_strap_disable,
  input  wire logic [2:0]              fuse_boot_src,
  input  wire logic                    fuse_clk_ext,
  input  wire bspc_pkg::bspc_sleep_t   sleep_mode,
  input  wire logic [NPAD-1:0]         pad_in,
  output logic [NPAD*3-1:0]            pad_func,
  output logic [NPAD*4-1:0]            pad_drive,
  output logic [NPAD-1:0]              pad_pull_up,
  output logic [NPAD-1:0]              pad_pull_dn,
  output logic [NPAD-1:0]              pad_out,
  output logic [NPAD-1:0]              pad_oe,
  output logic [NPAD-1:0]              pad_power_en,
  output logic [NPAD*7-1:0]            pad_remap,
  output bspc_pkg::bspc_boot_info_t    boot_info,
  output logic                         clk_ext_sel,
  output logic                         wake_req,
  output logic                         irq
);
  import bspc_pkg::*;

  // Pins cross into the clock domain before anything looks at them
  logic [NPAD+1:0] sync_q;
  bspc_sync2 #(.W(NPAD + 2)) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({strap_pad_high, strap_pad_low, pad_in}),
    .q       (sync_q)
  );
  wire [1:0]      strap_now = sync_q[NPAD+1:NPAD];
  wire [NPAD-1:0] pin_now   = sync_q[NPAD-1:0];

  // Register state
  bspc_bstate_t  bstate_r;
  logic [1:0]    settle_r;
  bspc_boot_t    boot_src_r;
  logic          boot_fuse_r;
  logic          serial_r;
  logic          clk_ext_r;
  logic          clk_lock_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [NWAKE-1:0] wake_en_r;
  logic [NWAKE-1:0] wake_prev_r;
  logic          wake_r;
  logic [DATA_W-1:0] rdata_r;
  bspc_pad_cfg_t pad_cfg_r [NPAD];
  bspc_remap_t   remap_r   [NPAD];

  // Fuse code decode; strap pair handled separately below
  function automatic bspc_boot_t fuse_decode(input logic [2:0] code);
    case (code)
      3'h1:    fuse_decode = BOOT_JTAG;
      3'h2:    fuse_decode = BOOT_DDR_FLASH;
      3'h4:    fuse_decode = BOOT_SERIAL;
      default: fuse_decode = BOOT_MRAM;   // Unknown code falls back to on-chip memory
    endcase
  endfunction : fuse_decode

  wire        use_fuse  = fuse_strap_disable | (strap_now == 2'b00);
  wire bspc_boot_t strap_src = (strap_now == 2'b01) ? BOOT_JTAG :
                               (strap_now == 2'b10) ? BOOT_DDR_FLASH : BOOT_MRAM;
  wire bspc_boot_t boot_nxt  = use_fuse ? fuse_decode(fuse_boot_src) : strap_src;

  // Bus decode
  wire [3:0] idx      = bus_req.addr[5:2];
  wire       idx_ok   = 32'(idx) < NPAD;
  wire       wr_ctrl  = bus_req.wr && bus_req.addr == REG_CTRL;
  wire       wr_mask  = bus_req.wr && bus_req.addr == REG_IRQ_MASK;
  wire       wr_wake  = bus_req.wr && bus_req.addr == REG_WAKE_EN;
  wire       pad_pg   = bus_req.addr[7:6] == REG_PAD_PAGE && bus_req.addr[1:0] == 2'b00;
  wire       remap_pg = bus_req.addr[7:6] == REG_REMAP_PAGE && bus_req.addr[1:0] == 2'b00;
  wire       wr_pad   = bus_req.wr && pad_pg && idx_ok;
  wire       wr_remap = bus_req.wr && remap_pg && idx_ok;
  wire       rd_stat  = bus_req.rd && bus_req.addr == REG_IRQ_STAT;

  // Secondary serial-flash stage is granted only after an MRAM primary boot
  wire second_req = wr_ctrl && bus_req.wdata[CTRL_SECOND_BIT];
  wire second_ok  = second_req && boot_src_r == BOOT_MRAM && bstate_r == BS_HOLD;
  wire refuse_ev  = second_req && !second_ok;

  // Drive request clamped to the pad's range
  wire [3:0] drv_req = bus_req.wdata[8:5];
  wire [3:0] drv_nxt = (drv_req > DRIVE_MAX_MA) ? DRIVE_MAX_MA :
                       (drv_req < DRIVE_MIN_MA) ? DRIVE_MIN_MA : drv_req;
  wire bspc_pad_cfg_t cfg_wr = '{oe: bus_req.wdata[10], out: bus_req.wdata[9],
                                 drive: drv_nxt, pull_dn: bus_req.wdata[4],
                                 pull_up: bus_req.wdata[3],
                                 func: DED_MASK[idx] ? FUNC_DEDICATED : bus_req.wdata[2:0]};
  wire       remap_sel_ok = bus_req.wdata[5:0] < REMAP_COUNT;

  // Wake detection on the always-on wake-capable pads
  wire deep_sleep = sleep_mode == SLP_RETAIN || sleep_mode == SLP_DEEP;
  wire [NWAKE-1:0] wake_edge = (pin_now[NWAKE-1:0] ^ wake_prev_r) & wake_en_r;
  wire wake_ev    = deep_sleep && |wake_edge;

  // Interrupt events, set beats read-clear
  wire [IRQ_W-1:0] irq_ev = {refuse_ev, wake_ev, bstate_r == BS_LATCH};
  wire [IRQ_W-1:0] irq_nxt = (rd_stat ? '0 : irq_stat_r) | irq_ev;

  // Read mux
  wire [DATA_W-1:0] rd_mux =
    (bus_req.addr == REG_BOOT_STAT) ? DATA_W'({boot_info, clk_ext_r}) :
    (bus_req.addr == REG_CTRL)      ? DATA_W'({clk_lock_r, serial_r, clk_ext_r}) :
    (bus_req.addr == REG_IRQ_STAT)  ? DATA_W'(irq_stat_r) :
    (bus_req.addr == REG_IRQ_MASK)  ? DATA_W'(irq_mask_r) :
    (bus_req.addr == REG_WAKE_EN)   ? DATA_W'(wake_en_r) :
    (pad_pg && idx_ok)              ? DATA_W'(pad_cfg_r[idx]) :
    (remap_pg && idx_ok)            ? DATA_W'(remap_r[idx]) : '0;

  // Strap sampler: waits for the synchroniser, latches once, then holds
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bstate_r <= BS_SETTLE;
      settle_r <= 2'h0;
    end else begin
      case (bstate_r)
        BS_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == STRAP_SETTLE - 2'h1) bstate_r <= BS_LATCH;
        end
        BS_LATCH: bstate_r <= BS_HOLD;
        BS_HOLD:  bstate_r <= BS_HOLD;
        default:  bstate_r <= BS_SETTLE;
      endcase
    end
  end

  // Boot selection captured once per reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      boot_src_r  <= BOOT_NONE;
      boot_fuse_r <= 1'b0;
    end else if (bstate_r == BS_LATCH) begin
      boot_src_r  <= boot_nxt;
      boot_fuse_r <= use_fuse;
    end
  end

  // Serial stage grant and fast clock source choice
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      serial_r   <= 1'b0;
      clk_ext_r  <= 1'b0;
      clk_lock_r <= 1'b0;
    end else begin
      if (second_ok) serial_r <= 1'b1;
      if (bstate_r == BS_LATCH) begin
        clk_ext_r <= fuse_clk_ext;
      end else if (wr_ctrl && !clk_lock_r && bstate_r == BS_HOLD) begin
        // Bootloader may rewrite the choice until a write sets the lock bit; later writes cannot glitch the clock
        clk_ext_r  <= bus_req.wdata[CTRL_CLK_EXT_BIT];
        clk_lock_r <= bus_req.wdata[CTRL_CLK_LOCK_BIT];
      end
    end
  end

  // Interrupt, wake enable and read data registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r  <= '0;
      irq_mask_r  <= '0;
      wake_en_r   <= '0;
      wake_prev_r <= '0;
      wake_r      <= 1'b0;
      rdata_r     <= '0;
    end else begin
      irq_stat_r  <= irq_nxt;
      if (wr_mask) irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
      if (wr_wake) wake_en_r <= bus_req.wdata[NWAKE-1:0];
      wake_prev_r <= pin_now[NWAKE-1:0];
      wake_r      <= wake_ev;
      rdata_r     <= bus_req.rd ? rd_mux : '0;
    end
  end

  // Pad configuration; sleep never touches it so light sleep exits unchanged
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NPAD; i++) begin
        pad_cfg_r[i] <= PAD_CFG_RST;
        if (DED_MASK[i]) pad_cfg_r[i].func <= FUNC_DEDICATED;
        remap_r[i]   <= REMAP_RST;
      end
    end else begin
      if (wr_pad) pad_cfg_r[idx] <= cfg_wr;
      if (wr_remap && REMAP_MASK[idx] && remap_sel_ok) begin
        remap_r[idx] <= '{en: bus_req.wdata[6], sel: bus_req.wdata[5:0]};
      end
    end
  end

  // Registered pad outputs with sleep gating per pad type
  for (genvar g = 0; g < NPAD; g++) begin : g_pad
    wire pwr_off = deep_sleep && !AON_MASK[g];
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        pad_func[g*3 +: 3]  <= DED_MASK[g] ? FUNC_DEDICATED : FUNC_GPIO;
        pad_drive[g*4 +: 4] <= DRIVE_RST_MA;
        pad_pull_up[g]      <= 1'b0;
        pad_pull_dn[g]      <= 1'b0;
        pad_out[g]          <= 1'b0;
        pad_oe[g]           <= 1'b0;
        pad_power_en[g]     <= 1'b1;
        pad_remap[g*7 +: 7] <= '0;
      end else begin
        pad_func[g*3 +: 3]  <= pad_cfg_r[g].func;
        pad_drive[g*4 +: 4] <= pad_cfg_r[g].drive;
        pad_pull_up[g]      <= pad_cfg_r[g].pull_up & !pwr_off;
        pad_pull_dn[g]      <= pad_cfg_r[g].pull_dn & !pwr_off;
        pad_out[g]          <= pad_cfg_r[g].out & !pwr_off;
        pad_oe[g]           <= pad_cfg_r[g].oe & !pwr_off;
        pad_power_en[g]     <= !pwr_off;
        pad_remap[g*7 +: 7] <= remap_r[g];
      end
    end
  end

  assign boot_info   = '{valid: bstate_r == BS_HOLD, from_fuse: boot_fuse_r,
                         serial_stage: serial_r, src: boot_src_r};
  assign clk_ext_sel = clk_ext_r;
  assign wake_req    = wake_r;
  assign irq         = |(irq_stat_r & irq_mask_r);
  assign bus_rdata   = rdata_r;

  // Helpers for the checks below
  logic any_pad_wr_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) any_pad_wr_r <= 1'b0;
    else if (wr_pad) any_pad_wr_r <= 1'b1;
  end
  logic [NPAD-1:0] drv_ok;
  for (genvar g = 0; g < NPAD; g++) begin : g_chk
    assign drv_ok[g] = pad_drive[g*4 +: 4] <= DRIVE_MAX_MA;
  end

  property p_latch_at_release;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(nrst) ##0 1 |-> ##3 boot_info.valid;
  endproperty
  a_latch_at_release: assert property (p_latch_at_release) else $error("boot not latched");

  property p_zero_straps_fuse;
    @(posedge ref_clk) disable iff (!nrst)
      bstate_r == BS_LATCH && strap_now == 2'b00 |=> boot_info.from_fuse;
  endproperty
  a_zero_straps_fuse: assert property (p_zero_straps_fuse) else $error("00 not fuse");

  property p_strap_decode;
    @(posedge ref_clk) disable iff (!nrst)
      bstate_r == BS_LATCH && !fuse_strap_disable && strap_now == 2'b10
      |=> boot_info.src == BOOT_DDR_FLASH && !boot_info.from_fuse;
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("bad strap decode");

  property p_fuse_disable;
    @(posedge ref_clk) disable iff (!nrst)
      bstate_r == BS_LATCH && fuse_strap_disable |=> boot_info.from_fuse;
  endproperty
  a_fuse_disable: assert property (p_fuse_disable) else $error("straps not ignored");

  property p_serial_gate;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(serial_r) |-> $past(boot_src_r) == BOOT_MRAM;
  endproperty
  a_serial_gate: assert property (p_serial_gate) else $error("serial stage w/o MRAM");

  property p_reset_gpio;
    @(posedge ref_clk) disable iff (!nrst)
      !any_pad_wr_r && !DED_MASK[0] |-> pad_func[2:0] == FUNC_GPIO && !pad_pull_up[0]
                                        && !pad_pull_dn[0] && !pad_oe[0];
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) else $error("pad 0 not GPIO input");

  property p_dedicated_kept;
    @(posedge ref_clk) disable iff (!nrst)
      DED_MASK[NPAD-1] |-> pad_func[NPAD*3-1 -: 3] == FUNC_DEDICATED;
  endproperty
  a_dedicated_kept: assert property (p_dedicated_kept) else $error("dedicated pad moved");

  property p_wake;
    @(posedge ref_clk) disable iff (!nrst)
      deep_sleep && (wake_edge != '0) |=> wake_req ##1 irq_stat_r[IRQ_WAKE_BIT];
  endproperty
  a_wake: assert property (p_wake) else $error("wake event missed");

  property p_switched_off;
    @(posedge ref_clk) disable iff (!nrst)
      sleep_mode == SLP_DEEP && !AON_MASK[NPAD-1] |=> !pad_power_en[NPAD-1]
                                                      && !pad_oe[NPAD-1];
  endproperty
  a_switched_off: assert property (p_switched_off) else $error("switched pad powered");

  property p_drive_max;
    @(posedge ref_clk) disable iff (!nrst) &drv_ok;
  endproperty
  a_drive_max: assert property (p_drive_max) else $error("drive above limit");

  property p_hold_selection;
    @(posedge ref_clk) disable iff (!nrst)
      boot_info.valid |=> $stable(boot_info.src) && $stable(boot_info.from_fuse);
  endproperty
  a_hold_selection: assert property (p_hold_selection) else $error("boot changed");

endmodule : bspc_top

// File: bench/bspc_board_model.sv
`timescale 1ns/1ps
// Board around the block: strap resistors, wake buttons, external clock, memory select gate
module bspc_board_model
  import bspc_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire bspc_pkg::bspc_sleep_t sleep_mode,
  input  wire logic [1:0]            strap_sel,
  input  wire logic [11:0]           aon_lvl,
  input  wire logic [15:0]           pad_out,
  input  wire logic [15:0]           pad_oe,
  output logic                       strap_pad_high,
  output logic                       strap_pad_low,
  output logic [15:0]                pad_in,
  output logic                       mem_cs_n
);
  logic asleep;
  logic clk_src = 1'b0;

  // Strap resistors hold the pins steady through reset release
  assign strap_pad_high = strap_sel[1];
  assign strap_pad_low  = strap_sel[0];
  assign asleep         = (sleep_mode == SLP_RETAIN) || (sleep_mode == SLP_DEEP);

  // External fast clock free-runs awake, parks low asleep
  always @(posedge ref_clk) begin
    clk_src <= asleep ? 1'b0 : ~clk_src;
  end

  // Switched pads are never pulled high while unpowered; pad 12 carries the clock, pads 13-15 a board pull-up otherwise
  assign pad_in[11:0]  = aon_lvl;
  assign pad_in[12]    = clk_src & ~asleep;
  assign pad_in[15:13] = asleep ? 3'h0 : (pad_oe[15:13] & pad_out[15:13]) | ~pad_oe[15:13];
  // Always-on pad 3 keeps the memory select inactive while pad 13 is off
  assign mem_cs_n      = pad_out[13] | pad_out[3];
endmodule : bspc_board_model

// File: bench/bspc_top_test.sv
`timescale 1ns/1ps
module bspc_top_test;
  import bspc_pkg::*;
  localparam logic [15:0] DED = 16'hc000;
  // Table entry: strap[10:9] disable[8] fuse_src[7:5] fuse_clk[4] exp_src[3:1] exp_fuse[0]
  localparam logic [10:0] BT [7] = '{11'b01_0_000_0_001_0, 11'b10_0_000_1_010_0,
                                     11'b11_0_000_0_011_0, 11'b00_0_100_0_100_1,
                                     11'b00_0_001_1_001_1, 11'b01_1_010_0_010_1,
                                     11'b11_1_111_0_011_1};
  logic            ref_clk;
  logic            nrst;
  bspc_bus_req_t   bus_req;
  logic [31:0]     bus_rdata;
  logic            sp_high;
  logic            sp_low;
  logic            fuse_strap_disable;
  logic [2:0]      fuse_boot_src;
  logic            fuse_clk_ext;
  bspc_sleep_t     sleep_mode;
  logic [15:0]     pad_in;
  logic [47:0]     pad_func;
  logic [63:0]     pad_drive;
  logic [15:0]     pad_pull_up;
  logic [15:0]     pad_pull_dn;
  logic [15:0]     pad_out;
  logic [15:0]     pad_oe;
  logic [15:0]     pad_power_en;
  logic [111:0]    pad_remap;
  bspc_boot_info_t boot_info;
  logic            clk_ext_sel;
  logic            wake_req;
  logic            irq;
  logic [1:0]      strap_sel;
  logic [11:0]     aon_lvl;
  logic [31:0]     got;
  logic            seen;
  int              err_count;
  int              n_checks;

  bspc_top i_bspc_top (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .strap_pad_high(sp_high), .strap_pad_low(sp_low),
    .fuse_strap_disable(fuse_strap_disable), .fuse_boot_src(fuse_boot_src),
    .fuse_clk_ext(fuse_clk_ext), .sleep_mode(sleep_mode), .pad_in(pad_in),
    .pad_func(pad_func), .pad_drive(pad_drive), .pad_pull_up(pad_pull_up),
    .pad_pull_dn(pad_pull_dn), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_power_en(pad_power_en), .pad_remap(pad_remap), .boot_info(boot_info),
    .clk_ext_sel(clk_ext_sel), .wake_req(wake_req), .irq(irq));

  bspc_board_model i_bspc_board_model (.ref_clk(ref_clk), .sleep_mode(sleep_mode),
    .strap_sel(strap_sel), .aon_lvl(aon_lvl), .pad_out(pad_out), .pad_oe(pad_oe),
    .strap_pad_high(sp_high), .strap_pad_low(sp_low), .pad_in(pad_in), .mem_cs_n());

  // 25 MHz reference clock
  always #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      err_count++;
    end
  endtask : chk

  // Bus strobes last one cycle; read data stand in the following cycle only
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask : bus_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, got);
    chk(got, e);
  endtask : rd_chk

  // Outputs trail their configuration by one cycle
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic [10:0] e);
    @(posedge ref_clk);
    nrst               <= 1'b0;
    strap_sel          <= e[10:9];
    fuse_strap_disable <= e[8];
    fuse_boot_src      <= e[7:5];
    fuse_clk_ext       <= e[4];
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : do_reset

  task automatic watch_wake(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (wake_req === 1'b1) seen = 1'b1;
    end
  endtask : watch_wake

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    report_and_stop;
  end

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    bus_req = '0;
    strap_sel = 2'h0;
    fuse_strap_disable = 1'b0;
    fuse_boot_src = 3'h0;
    fuse_clk_ext = 1'b0;
    sleep_mode = SLP_AWAKE;
    aon_lvl = 12'h0;
    err_count = 0;
    n_checks = 0;
    do_reset(BT[0]);
    for (int i = 0; i < 16; i++) begin
      chk(pad_func[i*3 +: 3], DED[i] ? 3'h0 : 3'h1);
    end
    chk(pad_pull_up | pad_pull_dn | pad_oe, 16'h0);
    // Seven strap pair and fuse combinations, then straps move after latch
    for (int k = 0; k < 7; k++) begin
      do_reset(BT[k]);
      bus_rd(REG_BOOT_STAT, got);
      chk(got & 32'h6f, {25'h1, BT[k][0], 1'b0, BT[k][3:1], BT[k][4]});
      chk(clk_ext_sel, BT[k][4]);
      @(posedge ref_clk);
      strap_sel <= ~BT[k][10:9];
      settle;
      chk(boot_info.src, BT[k][3:1]);
    end
    // Second stage refused after a flash boot
    do_reset(BT[1]);
    bus_wr(REG_CTRL, 32'h2);
    settle;
    chk(boot_info.serial_stage, 1'b0);
    bus_wr(REG_IRQ_MASK, 32'h4);
    settle;
    chk(irq, 1'b1);
    rd_chk(REG_IRQ_STAT, 32'h5);
    settle;
    chk(irq, 1'b0);
    rd_chk(REG_IRQ_STAT, 32'h0);
    bus_wr(REG_CTRL, 32'h0);
    settle;
    chk(clk_ext_sel, 1'b0);
    // Second stage granted after a magnetic memory boot
    do_reset(BT[2]);
    bus_wr(REG_CTRL, 32'h3);
    settle;
    chk(boot_info.serial_stage, 1'b1);
    chk(clk_ext_sel, 1'b1);
    // Lock freezes the clock choice until the next reset
    bus_wr(REG_CTRL, 32'h4);
    bus_wr(REG_CTRL, 32'h1);
    rd_chk(REG_CTRL, 32'h6);
    chk(clk_ext_sel, 1'b0);
    rd_chk(REG_IRQ_STAT, 32'h1);
    // Drive clamps at both ends, pulls independent, dedicated function fixed
    bus_wr(8'h4c, 32'h1d);
    rd_chk(8'h4c, 32'h3d);
    bus_wr(8'h4c, 32'h7e9);
    rd_chk(8'h4c, 32'h789);
    settle;
    chk(pad_drive[12 +: 4], DRIVE_MAX_MA);
    chk({pad_pull_up[3], pad_pull_dn[3]}, 2'b10);
    bus_wr(8'h74, 32'h641);
    bus_wr(8'h78, 32'h43);
    rd_chk(8'h78, 32'h40);
    // Remap: last legal selector, out-of-range selector, fixed pad, hole
    bus_wr(8'h88, 32'h63);
    rd_chk(8'h88, 32'h63);
    settle;
    chk(pad_remap[14 +: 7], 7'h63);
    bus_wr(8'h88, 32'h64);
    rd_chk(8'h88, 32'h63);
    bus_wr(8'ha4, 32'h41);
    rd_chk(8'ha4, 32'h0);
    rd_chk(8'hfc, 32'h0);
    // Light sleep keeps switched pads; deep sleep drops them
    @(posedge ref_clk);
    sleep_mode <= SLP_LIGHT;
    settle;
    chk({pad_power_en[13], pad_out[13]}, 2'b11);
    @(posedge ref_clk);
    sleep_mode <= SLP_DEEP;
    settle;
    chk({pad_power_en[13], pad_out[13], pad_oe[13]}, 3'b000);
    chk({pad_power_en[3], pad_out[3], pad_oe[3]}, 3'b111);
    // Only an enabled always-on pad wakes the block, deep or retentive
    bus_wr(REG_WAKE_EN, 32'h20);
    bus_wr(REG_IRQ_MASK, 32'h2);
    bus_rd(REG_IRQ_STAT, got);
    @(posedge ref_clk);
    aon_lvl[6] <= 1'b1;
    watch_wake(8);
    chk(seen, 1'b0);
    @(posedge ref_clk);
    sleep_mode <= SLP_RETAIN;
    aon_lvl[5] <= 1'b1;
    watch_wake(6);
    chk(seen, 1'b1);
    chk(irq, 1'b1);
    chk(pad_power_en[13], 1'b0);
    @(posedge ref_clk);
    sleep_mode <= SLP_AWAKE;
    settle;
    rd_chk(8'h74, 32'h641);
    chk({pad_power_en[13], pad_out[13]}, 2'b11);
    report_and_stop;
  end
endmodule : bspc_top_test
